// *** hw/sfepd_pkg.sv ***
// constants, commands and carriers for the flash erase and power-down sequencer
package sfepd_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // opcodes, most significant bit first on the serial input
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_ARRAY_ERASE = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP_ENTER = 8'hB9;
  localparam logic [7:0] OP_DEEP_SLEEP_RELEASE = 8'hAB;

  // frame geometry
  localparam int BIT_COUNT_W = 6;
  localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;
  localparam logic [5:0] SHORT_FRAME_BITS = 6'h08;
  localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
  localparam int SHIFT_W = 32;
  localparam int SECTOR_LSB = 16;
  localparam int ADDR_USED_MSB = 18;
  localparam int SECTOR_FIELD_W = 8;

  // self-timed cycle lengths
  localparam int SECTOR_ERASE_TIME_US = 1000;
  localparam int ARRAY_ERASE_TIME_US = 4000;
  localparam int DEEP_SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int DEEP_SLEEP_EXIT_DELAY_NS = 30000;
  localparam int SECTOR_ERASE_CYCLES =
    (SECTOR_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_ERASE_CYCLES =
    (ARRAY_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_SLEEP_ENTRY_CYCLES =
    (DEEP_SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_SLEEP_EXIT_CYCLES =
    (DEEP_SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 32;

  typedef struct packed {
    logic [BIT_COUNT_W-1:0] bit_count;
    logic [SHIFT_W-1:0] shift;
  } sfepd_frame_type;

  typedef struct packed {
    logic cycle_in_progress_flag;
    logic write_unlock_latch;
    logic standby;
    logic deep_sleep;
  } sfepd_status_type;

  typedef struct packed {
    logic start;
    logic active;
    logic whole;
    logic [SECTOR_FIELD_W-1:0] sector;
  } sfepd_erase_type;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_SECTOR_ERASE,
    ST_ARRAY_ERASE,
    ST_SLEEP_ENTRY,
    ST_DEEP_SLEEP,
    ST_SLEEP_EXIT
  } sfepd_state_type;

endpackage : sfepd_pkg

// *** hw/sfepd_ctrl.sv ***
// erase and deep power-down instruction sequencer behind the serial link
// How it works
// RL1 - sector erase fills addressed sector with FFh
// RL2 - erases need write unlock latch set first
// RL3 - opcode plus three address bytes, A23-A19 ignored
// RL4 - sector erase only on deselect after bit 32
// RL5 - sector erase start sets busy flag till done
// RL6 - unlock latch cleared during every erase cycle
// RL7 - no sector erase on hardware-protected sector
// RL8 - erase, sleep, wake refused while cycle runs
// RL9 - status stays visible during self-timed cycle
// RL10 - array erase is opcode only, fills FFh
// RL11 - array erase, sleep need deselect after bit 8
// RL12 - array erase sets busy flag till done
// RL13 - array erase ignored if anything is protected
// RL14 - reset aborts cycle; host waits before select
// RL15 - only sleep command enters deep sleep
// RL16 - deselect gives standby only when idle
// RL17 - in deep sleep only release is heard
// RL18 - deep sleep entered after entry delay
// RL19 - release rejected when extra clocks arrive
// RL20 - standby after release delay elapses
// RL21 - power-up always lands in standby
// RL22 - host keeps select low through frame
// RL23 - msb first, sampled on rising link clock
`timescale 1ns/1ps
module sfepd_ctrl
  import sfepd_pkg::*;
#(
  parameter int SECTOR_COUNT = 8,
  parameter int SECTOR_ERASE_CYCLES_P = SECTOR_ERASE_CYCLES,
  parameter int ARRAY_ERASE_CYCLES_P = ARRAY_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  input wire logic [SECTOR_COUNT-1:0] hw_protect,
  input wire logic [SECTOR_COUNT-1:0] sw_protect,
  input wire logic other_cycle_busy,
  output sfepd_status_type status,
  output sfepd_erase_type erase
);

  localparam int SECTOR_BITS = $clog2(SECTOR_COUNT);

  // sector index must sit inside A18..A16
  if (SECTOR_COUNT < 2 || SECTOR_COUNT != (1 << SECTOR_BITS) ||
      SECTOR_LSB + SECTOR_BITS > ADDR_USED_MSB + 1) begin : g_bad_sectors
    $error("sector count must be a power of two from 2 to 8");
  end
  if (SECTOR_ERASE_CYCLES_P < 1 || ARRAY_ERASE_CYCLES_P < 1) begin : g_bad_times
    $error("erase cycle counts must be at least one");
  end

  function automatic logic frame_is(input sfepd_frame_type f, input logic [7:0] op,
                                    input logic [BIT_COUNT_W-1:0] bits);
    logic [7:0] got;
    got = (bits == ADDR_FRAME_BITS) ? f.shift[SHIFT_W-1 -: 8] : f.shift[7:0];
    return (f.bit_count == bits) && (got == op);
  endfunction : frame_is

  // ---------------- link clock domain ----------------
  logic fresh;
  sfepd_frame_type link_frame;
  logic link_toggle;

  // raised while deselected; the first clock edge of a frame sees it
  always_ff @(posedge link_sck or posedge link_cs_n) begin
    if (link_cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // bits held static once the clock stops, so the core may read them later
  always_ff @(posedge link_sck or negedge rst_n) begin
    if (!rst_n) begin
      link_frame <= '0;
    end else if (fresh) begin
      link_frame.bit_count <= BIT_COUNT_W'(1);
      link_frame.shift <= {{(SHIFT_W-1){1'b0}}, link_mosi}; // RL23
    end else begin
      if (link_frame.bit_count != BIT_COUNT_MAX) begin
        link_frame.bit_count <= link_frame.bit_count + BIT_COUNT_W'(1); // RL19
      end
      link_frame.shift <= {link_frame.shift[SHIFT_W-2:0], link_mosi}; // RL23
    end
  end

  // marks that a frame carried clocks, so a bare select pulse replays nothing
  always_ff @(posedge link_sck or negedge rst_n) begin
    if (!rst_n) begin
      link_toggle <= 1'b0;
    end else if (fresh) begin
      link_toggle <= ~link_toggle;
    end
  end

  // ---------------- core clock domain ----------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      cs_meta <= link_cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
      if (cs_sync && !cs_prev) begin
        tog_seen <= tog_sync;
      end
    end
  end

  sfepd_state_type state;
  sfepd_state_type next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic unlock_latch;
  logic take;
  logic cycle_busy;
  logic [SECTOR_BITS-1:0] sector_idx;
  logic cmd_unlock;
  logic cmd_sector;
  logic cmd_array;
  logic cmd_sleep;
  logic cmd_release;

  // deselect edge closes the frame; link bits have been still for two clocks
  assign take = cs_sync && !cs_prev && (tog_sync != tog_seen); // RL22
  assign cycle_busy = (state == ST_SECTOR_ERASE) || (state == ST_ARRAY_ERASE) ||
                      other_cycle_busy;
  assign sector_idx = link_frame.shift[SECTOR_LSB +: SECTOR_BITS]; // RL3

  always_comb begin
    cmd_unlock = take && (state == ST_STANDBY) && !cycle_busy &&
                 frame_is(link_frame, OP_WRITE_UNLOCK, SHORT_FRAME_BITS);
    cmd_sector = take && (state == ST_STANDBY) && !cycle_busy && unlock_latch && // RL2 RL8
                 frame_is(link_frame, OP_SECTOR_ERASE, ADDR_FRAME_BITS) && // RL4
                 !hw_protect[sector_idx]; // RL7
    cmd_array = take && (state == ST_STANDBY) && !cycle_busy && unlock_latch && // RL2 RL8
                frame_is(link_frame, OP_WHOLE_ARRAY_ERASE, SHORT_FRAME_BITS) && // RL10 RL11
                !(|(hw_protect | sw_protect)); // RL13
    cmd_sleep = take && (state == ST_STANDBY) && !cycle_busy && // RL8
                frame_is(link_frame, OP_DEEP_SLEEP_ENTER, SHORT_FRAME_BITS); // RL11 RL15
    // exact count of eight: any extra clock makes the frame longer
    cmd_release = take && (state == ST_DEEP_SLEEP) && !other_cycle_busy && // RL17 RL8
                  frame_is(link_frame, OP_DEEP_SLEEP_RELEASE, SHORT_FRAME_BITS); // RL19
  end

  always_comb begin
    next_state = state;
    next_timer = (timer != '0) ? timer - TIMER_W'(1) : timer;
    unique case (state)
      ST_STANDBY: begin
        if (cmd_sector) begin
          next_state = ST_SECTOR_ERASE; // RL5
          next_timer = TIMER_W'(SECTOR_ERASE_CYCLES_P - 1);
        end else if (cmd_array) begin
          next_state = ST_ARRAY_ERASE; // RL12
          next_timer = TIMER_W'(ARRAY_ERASE_CYCLES_P - 1);
        end else if (cmd_sleep) begin
          next_state = ST_SLEEP_ENTRY; // RL18
          next_timer = TIMER_W'(DEEP_SLEEP_ENTRY_CYCLES - 1);
        end
      end
      ST_SECTOR_ERASE, ST_ARRAY_ERASE: begin
        if (timer == '0) begin
          next_state = ST_STANDBY; // RL5 RL12
        end
      end
      ST_SLEEP_ENTRY: begin
        if (timer == '0) begin
          next_state = ST_DEEP_SLEEP; // RL18
        end
      end
      ST_DEEP_SLEEP: begin
        if (cmd_release) begin
          next_state = ST_SLEEP_EXIT; // RL20
          next_timer = TIMER_W'(DEEP_SLEEP_EXIT_CYCLES - 1);
        end
      end
      ST_SLEEP_EXIT: begin
        if (timer == '0) begin
          next_state = ST_STANDBY; // RL20
        end
      end
      // two spare codes of the state register fall back to standby
      default: begin
        next_state = ST_STANDBY;
        next_timer = '0;
      end
    endcase
  end

  // reset aborts any running cycle and returns to standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STANDBY; // RL14 RL21
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // cleared as the erase starts, well before the cycle ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_latch <= 1'b0;
    end else if (cmd_unlock) begin
      unlock_latch <= 1'b1;
    end else if (cmd_sector || cmd_array) begin
      unlock_latch <= 1'b0; // RL6
    end
  end

  // the array fills the target with FFh while active is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase <= '0;
    end else begin
      erase.start <= cmd_sector || cmd_array; // RL1 RL10
      erase.active <= (next_state == ST_SECTOR_ERASE) || (next_state == ST_ARRAY_ERASE);
      if (cmd_sector || cmd_array) begin
        erase.whole <= cmd_array;
        erase.sector <= cmd_array ? '0 : SECTOR_FIELD_W'(sector_idx); // RL3
      end
    end
  end

  // readable at any time, including mid-cycle, for completion polling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '{cycle_in_progress_flag: 1'b0, write_unlock_latch: 1'b0,
                  standby: 1'b1, deep_sleep: 1'b0}; // RL21
    end else begin
      status.cycle_in_progress_flag <= (next_state == ST_SECTOR_ERASE) || // RL9 RL5
                                       (next_state == ST_ARRAY_ERASE) || other_cycle_busy;
      status.write_unlock_latch <= cmd_unlock ? 1'b1 :
                                   (cmd_sector || cmd_array) ? 1'b0 : unlock_latch;
      status.standby <= (next_state == ST_STANDBY) && cs_sync && !other_cycle_busy; // RL16
      status.deep_sleep <= (next_state == ST_DEEP_SLEEP); // RL15
    end
  end

endmodule : sfepd_ctrl

// *** bench/sfepd_host.sv ***
// link master model driving frames on its own 12 ns serial clock
`timescale 1ns/1ps
module sfepd_host (
  output logic link_sck,
  output logic link_cs_n,
  output logic link_mosi
);
  initial begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end
  // data left aligned; sck stands low outside frames
  task automatic frame(input logic [31:0] d, input int n);
    link_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_mosi = d[31-i];
      #6 link_sck = 1'b1;
      #6 link_sck = 1'b0;
    end
    #3 link_cs_n = 1'b1;
    // released line must not keep its last value
    link_mosi = ~link_mosi;
  endtask : frame
endmodule : sfepd_host

// *** bench/sfepd_chk.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module sfepd_chk
  import sfepd_pkg::*;
#(
  parameter int SECTOR_COUNT = 8,
  parameter int SECTOR_ERASE_CYCLES_P = 20,
  parameter int ARRAY_ERASE_CYCLES_P = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_cs_n,
  input wire logic [SECTOR_COUNT-1:0] hw_protect,
  input wire logic [SECTOR_COUNT-1:0] sw_protect,
  input wire sfepd_status_type status,
  input wire sfepd_erase_type erase
);
  int run_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= erase.active ? run_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_one_cycle: assert property (erase.start |=> !erase.start)
    else $error("start pulse too long");
  a_start_latch_use: assert property (erase.start |->
    $past(status.write_unlock_latch) && !status.write_unlock_latch &&
    status.cycle_in_progress_flag) else $error("latch or flag wrong");
  a_start_deselected: assert property (erase.start |-> link_cs_n && $past(link_cs_n, 2))
    else $error("erase started while selected");
  a_no_restart: assert property (erase.start |-> !$past(erase.active))
    else $error("erase restarted while busy");
  a_protect_honoured: assert property (erase.start |-> (erase.whole ?
    (hw_protect | sw_protect) == '0 : !hw_protect[erase.sector])) else $error("protected erase");
  a_sleep_quiet: assert property (status.deep_sleep |-> !status.standby && !erase.active)
    else $error("deep sleep overlaps activity");
  a_standby_idle: assert property (status.standby |-> !erase.active)
    else $error("standby during erase");
  a_cycle_length: assert property ($fell(erase.active) |-> run_cnt ==
    ($past(erase.whole) ? ARRAY_ERASE_CYCLES_P : SECTOR_ERASE_CYCLES_P)) else $error("bad length");
endmodule : sfepd_chk
bind sfepd_ctrl sfepd_chk #(.SECTOR_COUNT(SECTOR_COUNT),
  .SECTOR_ERASE_CYCLES_P(SECTOR_ERASE_CYCLES_P),
  .ARRAY_ERASE_CYCLES_P(ARRAY_ERASE_CYCLES_P)) i_chk (.clk(clk), .rst_n(rst_n),
  .link_cs_n(link_cs_n), .hw_protect(hw_protect), .sw_protect(sw_protect), .status(status),
  .erase(erase));

// *** bench/sfepd_ctrl_tb_top.sv ***
// self-checking bench for the erase and deep power-down sequencer
`timescale 1ns/1ps
module sfepd_ctrl_tb_top;
  import sfepd_pkg::*;
  localparam logic [31:0] UNL = {OP_WRITE_UNLOCK, 24'h00_0000};
  localparam logic [31:0] AE = {OP_WHOLE_ARRAY_ERASE, 24'h00_0000};
  localparam logic [31:0] SLP = {OP_DEEP_SLEEP_ENTER, 24'h00_0000};
  localparam logic [31:0] REL = {OP_DEEP_SLEEP_RELEASE, 24'h00_0000};
  logic clk, rst_n, other_cycle_busy, link_sck, link_cs_n, link_mosi;
  logic [7:0] hw_protect, sw_protect;
  logic [31:0] se;
  sfepd_status_type status;
  sfepd_erase_type erase;
  int error_cnt, n_checks, cyc, seen;
  sfepd_host i_host (.link_sck(link_sck), .link_cs_n(link_cs_n), .link_mosi(link_mosi));
  sfepd_ctrl #(.SECTOR_ERASE_CYCLES_P(100), .ARRAY_ERASE_CYCLES_P(120)) i_dut (.clk(clk),
    .rst_n(rst_n), .link_sck(link_sck), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .hw_protect(hw_protect), .sw_protect(sw_protect), .other_cycle_busy(other_cycle_busy),
    .status(status), .erase(erase));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // one frame, then the expected start and latch against the design
  task automatic cmd(input logic [31:0] d, input int n, input int es, input int el);
    i_host.frame(d, n);
    seen = 0;
    repeat (8) @(posedge clk) if (erase.start === 1'b1) seen = 1;
    check("erase start", es, seen);
    check("unlock latch", el, status.write_unlock_latch);
  endtask : cmd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    other_cycle_busy = 1'b0;
    hw_protect = 8'h00;
    sw_protect = 8'h00;
    void'($urandom(96));
    se = {OP_SECTOR_ERASE, 24'($urandom)};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("status", 4'h2, status);
    cmd(se, 32, 0, 0);
    cmd(UNL, 8, 0, 1);
    cmd(se, 32, 1, 0);
    check("sector", se[18:16], erase.sector);
    check("busy flag", 1, status.cycle_in_progress_flag);
    cmd(UNL, 8, 0, 0);
    cmd(SLP, 8, 0, 0);
    for (int i = 0; i < 300 && erase.active !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check("idle status", 4'h2, status);
    cmd(UNL, 8, 0, 1);
    cmd(se, 31, 0, 1);
    hw_protect <= 8'h01 << se[18:16];
    cmd(se, 32, 0, 1);
    hw_protect <= 8'h00;
    sw_protect <= 8'h80;
    cmd(AE, 8, 0, 1);
    sw_protect <= 8'h00;
    cmd(AE, 9, 0, 1);
    other_cycle_busy <= 1'b1;
    cmd(AE, 8, 0, 1);
    other_cycle_busy <= 1'b0;
    cmd(AE, 8, 1, 0);
    check("whole", 1, erase.whole);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check("aborted", 4'h2, {erase.active, status});
    cmd(SLP, 9, 0, 0);
    check("standby", 1, status.standby);
    cmd(SLP, 8, 0, 0);
    check("sleep early", 0, status.deep_sleep);
    repeat (400) @(posedge clk);
    check("sleep", 1, status.deep_sleep);
    cmd(UNL, 8, 0, 0);
    cmd(REL, 9, 0, 0);
    check("sleep kept", 1, status.deep_sleep);
    cmd(REL, 8, 0, 0);
    check("woken", 0, status.deep_sleep);
    repeat (3800) @(posedge clk);
    check("standby", 1, status.standby);
    report_and_stop();
  end
endmodule : sfepd_ctrl_tb_top
